/* File: rtl/jtx_cfg.svh */
// Constants for the JESD204C transmit link: characters, sizes, features
`ifndef JTX_CFG_SVH
`define JTX_CFG_SVH
`define JTX_LANES 16
`define JTX_LANE_W 5
`define JTX_OCT_W 8
`define JTX_FIFO_DEPTH 32
`define JTX_MF_W 10
`define JTX_K285 8'hBC
`define JTX_K280 8'h1C
`define JTX_K283 8'h7C
`define JTX_ILAS_LAST 2'h3
`define JTX_BLK_LAST 3'h7
`define JTX_HDR_DATA 2'h1
`define JTX_HDR_IDLE 2'h0
`define JTX_SCR_SEED 58'h3FFFFFFFFFFFFFF
`define JTX_SCR8_TAP_A 13
`define JTX_SCR8_TAP_B 14
`define JTX_SCR64_TAP_A 38
`define JTX_SCR64_TAP_B 57
// Feature word, bit per optional feature: 8b10b, 64b66b, 64b80b,
// command channel, FEC, CRC3, sync pin, sc0, sc1, sc2, lane align,
// multipoint align, 204A sync timing, 204B sync timing
`define JTX_FEATURES 14'h3553
`endif

/* File: rtl/jtx_pkg.sv */
// Types shared by the JESD204C transmit link
package jtx_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_CGS = 6'h02,
		ST_WAIT = 6'h04,
		ST_ILAS = 6'h08,
		ST_DATA = 6'h10,
		ST_BLK = 6'h20
	} jtx_state_e;
	typedef logic [57:0] jtx_scr_t;
	typedef logic [127:0] jtx_word_t;
endpackage

/* File: rtl/jtx_link.sv */
// JESD204C transmit link layer with its sample FIFO
`timescale 1ns/1ps
`include "jtx_cfg.svh"

// Sample buffer between the converter and the link
module jtx_fifo #(
	parameter int W = 128,
	parameter int DEPTH = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_reg [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	// Extra pointer bit tells full from empty
	assign in_ready = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) ||
		(wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
	assign out_valid = wr_ptr_reg != rd_ptr_reg;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

	// Storage, no reset needed on data
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule // jtx_fifo

module jtx_link (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic cfg_mode64,
	input wire logic [`JTX_LANE_W-1:0] cfg_lanes,
	input wire logic cfg_scr_en,
	input wire logic cfg_fec_en,
	input wire logic cfg_nco_sync_en,
	input wire logic [`JTX_MF_W-1:0] cfg_mf_len,
	input wire logic sync_req_n,
	input wire logic sysref,
	input wire logic s_valid,
	output logic s_ready,
	input wire jtx_pkg::jtx_word_t s_data,
	output logic [`JTX_LANES*8-1:0] lane_octet,
	output logic [`JTX_LANES-1:0] lane_is_k,
	output logic [`JTX_LANES*2-1:0] lane_hdr,
	output logic [`JTX_LANES*8-1:0] lane_par,
	output logic [`JTX_LANES-1:0] lane_en,
	output logic blk_start,
	output logic fec_active,
	output logic nco_sync,
	output logic link_up,
	output logic [13:0] features
);
	import jtx_pkg::*;

	jtx_state_e state_reg;
	logic sync_m_reg;
	logic sync_q_reg;
	logic sync_d_reg;
	logic ref_m_reg;
	logic ref_q_reg;
	logic ref_d_reg;
	logic sysref_rise;
	logic sync_fall;
	logic [`JTX_MF_W-1:0] lmfc_cnt_reg;
	logic lmfc_wrap;
	logic [1:0] ilas_mf_reg;
	logic [2:0] blk_cnt_reg;
	logic use_scr;
	logic f_valid;
	logic f_ready;
	jtx_word_t f_data;
	logic [7:0] oct_reg [`JTX_LANES];
	logic [1:0] hdr_reg [`JTX_LANES];
	logic [7:0] par_reg [`JTX_LANES];
	logic [7:0] acc_reg [`JTX_LANES];
	jtx_scr_t scr_reg [`JTX_LANES];
	logic [`JTX_LANES-1:0] k_reg;
	logic [`JTX_LANES-1:0] en_reg;
	logic blk_start_reg;
	logic nco_sync_reg;

	// Self-synchronous scrambler over one octet, polynomial by mode
	function automatic logic [65:0] scr_octet(input jtx_scr_t st,
		input logic [7:0] d, input logic m64);
		logic fb;
		logic [7:0] o;
		jtx_scr_t s;
		s = st;
		o = '0;
		for (int b = 7; b >= 0; b--) begin
			fb = m64 ? (s[`JTX_SCR64_TAP_A] ^ s[`JTX_SCR64_TAP_B]) :
				(s[`JTX_SCR8_TAP_A] ^ s[`JTX_SCR8_TAP_B]);
			o[b] = d[b] ^ fb;
			s = {s[56:0], o[b]};
		end
		return {s, o};
	endfunction

	assign features = `JTX_FEATURES;
	assign lane_en = en_reg;
	assign blk_start = blk_start_reg;
	assign nco_sync = nco_sync_reg;
	assign link_up = (state_reg == ST_DATA) || (state_reg == ST_BLK);
	assign fec_active = cfg_mode64 && cfg_fec_en;

	// Pins cross into the device clock; first flop feeds only the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_m_reg <= 1'b1;
			sync_q_reg <= 1'b1;
			sync_d_reg <= 1'b1;
			ref_m_reg <= 1'b0;
			ref_q_reg <= 1'b0;
			ref_d_reg <= 1'b0;
		end else begin
			sync_m_reg <= sync_req_n;
			sync_q_reg <= sync_m_reg;
			sync_d_reg <= sync_q_reg;
			ref_m_reg <= sysref;
			ref_q_reg <= ref_m_reg;
			ref_d_reg <= ref_q_reg;
		end
	end
	assign sysref_rise = ref_q_reg && !ref_d_reg;
	assign sync_fall = !sync_q_reg && sync_d_reg;

	// LMFC or LEMC counter, re-phased by SYSREF for deterministic latency
	assign lmfc_wrap = lmfc_cnt_reg == cfg_mf_len;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lmfc_cnt_reg <= '0;
		end else if (sysref_rise) begin
			lmfc_cnt_reg <= '0;
		end else if (lmfc_wrap) begin
			lmfc_cnt_reg <= '0;
		end else begin
			lmfc_cnt_reg <= lmfc_cnt_reg + 1'b1;
		end
	end

	// Link state; a mode change always restarts through idle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (cfg_mode64) begin
						state_reg <= ST_BLK;
					end else if (!sync_q_reg) begin
						state_reg <= ST_CGS;
					end
				end
				ST_CGS: begin
					if (cfg_mode64) begin
						state_reg <= ST_IDLE;
					end else if (sync_q_reg) begin
						state_reg <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (cfg_mode64) begin
						state_reg <= ST_IDLE;
					end else if (!sync_q_reg) begin
						state_reg <= ST_CGS;
					end else if (lmfc_wrap) begin
						state_reg <= ST_ILAS;
					end
				end
				ST_ILAS: begin
					if (cfg_mode64) begin
						state_reg <= ST_IDLE;
					end else if (!sync_q_reg) begin
						state_reg <= ST_CGS;
					end else if (lmfc_wrap && ilas_mf_reg == `JTX_ILAS_LAST) begin
						state_reg <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (cfg_mode64) begin
						state_reg <= ST_IDLE;
					end else if (!sync_q_reg) begin
						state_reg <= ST_CGS;
					end
				end
				ST_BLK: begin
					// Handshake plays no part here
					if (!cfg_mode64) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ILAS multiframe count: four multiframes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ilas_mf_reg <= '0;
		end else if (state_reg != ST_ILAS) begin
			ilas_mf_reg <= '0;
		end else if (lmfc_wrap) begin
			ilas_mf_reg <= ilas_mf_reg + 1'b1;
		end
	end

	// Block position within a 64-bit block of each lane
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			blk_cnt_reg <= '0;
			blk_start_reg <= 1'b0;
		end else begin
			blk_start_reg <= (state_reg == ST_BLK) && (blk_cnt_reg == '0);
			if (state_reg == ST_BLK) begin
				blk_cnt_reg <= blk_cnt_reg + 1'b1;
			end else begin
				blk_cnt_reg <= '0;
			end
		end
	end

	// NCO sync is the only use of the handshake in 64B/66B
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nco_sync_reg <= 1'b0;
		end else begin
			nco_sync_reg <= cfg_mode64 && cfg_nco_sync_en && sync_fall;
		end
	end

	// Drain the FIFO only in data states; an empty FIFO feeds zero octets, which go out scrambled when use_scr is set
	assign f_ready = (state_reg == ST_DATA) || (state_reg == ST_BLK);
	assign use_scr = (state_reg == ST_BLK) ||
		((state_reg == ST_DATA) && cfg_scr_en);

	jtx_fifo #(
		.W(128),
		.DEPTH(`JTX_FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(s_valid),
		.in_ready(s_ready),
		.in_data(s_data),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);

	// Per-lane character generation, all lanes on one shared timebase
	for (genvar i = 0; i < `JTX_LANES; i++) begin : g_lane
		logic [7:0] raw;
		logic [65:0] scr;
		assign raw = f_valid ? f_data[i*8 +: 8] : 8'h00;
		assign scr = scr_octet(scr_reg[i], raw, cfg_mode64);
		assign lane_octet[i*8 +: 8] = oct_reg[i];
		assign lane_is_k[i] = k_reg[i];
		assign lane_hdr[i*2 +: 2] = hdr_reg[i];
		assign lane_par[i*8 +: 8] = par_reg[i];

		// Octet, control flag and scrambler state
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				oct_reg[i] <= `JTX_K285;
				k_reg[i] <= 1'b1;
				scr_reg[i] <= `JTX_SCR_SEED;
				en_reg[i] <= 1'b0;
			end else begin
				en_reg[i] <= i < cfg_lanes;
				if (state_reg == ST_ILAS) begin
					// ILAS is never scrambled; /R/ opens, /A/ closes
					if (lmfc_cnt_reg == '0) begin
						oct_reg[i] <= `JTX_K280;
						k_reg[i] <= 1'b1;
					end else if (lmfc_wrap) begin
						oct_reg[i] <= `JTX_K283;
						k_reg[i] <= 1'b1;
					end else begin
						oct_reg[i] <= lmfc_cnt_reg[7:0];
						k_reg[i] <= 1'b0;
					end
				end else if (f_ready) begin
					oct_reg[i] <= use_scr ? scr[7:0] : raw;
					k_reg[i] <= 1'b0;
					if (use_scr) begin
						scr_reg[i] <= scr[65:8];
					end
				end else begin
					oct_reg[i] <= `JTX_K285;
					k_reg[i] <= 1'b1;
				end
			end
		end

		// Sync header and per-block FEC parity, 64B/66B only
		always_ff @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				hdr_reg[i] <= `JTX_HDR_IDLE;
				acc_reg[i] <= '0;
				par_reg[i] <= '0;
			end else if (state_reg != ST_BLK) begin
				hdr_reg[i] <= `JTX_HDR_IDLE;
				acc_reg[i] <= '0;
			end else begin
				hdr_reg[i] <= `JTX_HDR_DATA;
				if (blk_cnt_reg == `JTX_BLK_LAST) begin
					acc_reg[i] <= '0;
					if (fec_active) begin
						par_reg[i] <= acc_reg[i] ^ scr[7:0];
					end
				end else begin
					acc_reg[i] <= acc_reg[i] ^ scr[7:0];
				end
			end
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	cgs_comma_a: assert property (
		(state_reg == ST_CGS) |=> (k_reg == '1) &&
			(oct_reg[0] == `JTX_K285))
		else $error("comma not sent during code group sync");
	ilas_edge_a: assert property (
		(state_reg == ST_WAIT) && sync_q_reg && lmfc_wrap &&
			!cfg_mode64 |=> (state_reg == ST_ILAS) && (lmfc_cnt_reg == '0))
		else $error("ILAS not started on multiframe edge");
	ilas_r_a: assert property (
		(state_reg == ST_ILAS) && (lmfc_cnt_reg == '0) |=>
			(k_reg == '1) && (oct_reg[15] == `JTX_K280))
		else $error("ILAS multiframe not opened by R char");
	ilas_len_a: assert property (
		$rose(state_reg == ST_DATA) |-> $past(ilas_mf_reg) == 2'h3)
		else $error("ILAS not four multiframes long");
	sysref_a: assert property (
		sysref_rise |=> lmfc_cnt_reg == '0)
		else $error("SYSREF did not reset the multiframe counter");
	blk_hold_a: assert property (
		(state_reg == ST_BLK) && cfg_mode64 && $fell(sync_q_reg) |=>
			state_reg == ST_BLK)
		else $error("handshake disturbed 64B/66B link");
	hdr_data_a: assert property (
		blk_start_reg |-> hdr_reg[0] == `JTX_HDR_DATA)
		else $error("block start without data sync header");
	// Scrambler must shift one octet per block cycle and emit its output
	scr64_a: assert property (
		(state_reg == ST_BLK) |=> (oct_reg[0] == scr_reg[0][7:0]) &&
			(scr_reg[0][57:8] == $past(scr_reg[0][49:0])))
		else $error("scrambler idle in 64B/66B");
	lanes_a: assert property (
		$stable(cfg_lanes) && (cfg_lanes <= 5'h10) |=>
			$countones(en_reg) == $past(cfg_lanes))
		else $error("enabled lane count wrong");
	blk_per_a: assert property (
		blk_start_reg && (state_reg == ST_BLK) |=> !blk_start_reg [*7])
		else $error("sync header spacing not eight octets");

	link_cov: cover property ($rose(state_reg == ST_DATA));
	cgs_cov: cover property ((state_reg == ST_CGS) ##[1:50]
		(state_reg == ST_ILAS));
	blk_cov: cover property (blk_start_reg && fec_active);
	ref_cov: cover property (sysref_rise && (state_reg == ST_ILAS));
endmodule // jtx_link

/* File: dv/jtx_rx_model.sv */
// Behavioural JESD204C receiver that drives the active-low handshake
`timescale 1ns/1ps
module jtx_rx_model (
	input wire logic ref_clk,
	input wire logic go,
	input wire logic [3:0] lag,
	input wire logic [7:0] octet0,
	input wire logic is_k0,
	output logic sync_req_n
);
	int cnt = 0;
	initial sync_req_n = 1'b1;
	// Request sync, release after four commas plus a lag; the lag stands
	// for a slow receiver that waits for its own multiframe edge
	always @(posedge ref_clk) begin
		if (!go) begin
			sync_req_n <= 1'b1;
			cnt <= 0;
		end else if (cnt < 4 + lag) begin
			sync_req_n <= 1'b0;
			cnt <= (is_k0 === 1'b1 && octet0 === 8'hBC) ? cnt + 1 : 0;
		end else begin
			sync_req_n <= 1'b1;
		end
	end
endmodule // jtx_rx_model

/* File: dv/jtx_link_test.sv */
// Self-checking bench for the JESD204C transmit link
`timescale 1ns/1ps
`include "jtx_cfg.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module jtx_link_test;
	import jtx_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, cfg_mode64 = 1'b0, cfg_scr_en = 1'b0;
	logic cfg_fec_en = 1'b0, cfg_nco_sync_en = 1'b0, sysref = 1'b0;
	logic s_valid = 1'b0, go = 1'b0;
	logic [4:0] cfg_lanes = 5'h10;
	logic [3:0] lag = 4'h0;
	logic [9:0] cfg_mf_len = 10'h00F;
	jtx_word_t s_data = '0, msk, w, exp_q[$];
	logic sync_req_n, s_ready, blk_start, fec_active, nco_sync, link_up;
	logic [127:0] lane_octet, lane_par;
	logic [14:0] hist [16];
	logic [15:0] lane_is_k, lane_en, lmask;
	logic [31:0] lane_hdr, seed = 32'h012F;
	logic [13:0] features;
	int error_cnt = 0, check_count = 0, cyc = 0, ph0, ph1, got;

	// Device clock, 4 ns period
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
	end

	jtx_link jtx_link_inst (.ref_clk(ref_clk), .rst(rst),
		.cfg_mode64(cfg_mode64), .cfg_lanes(cfg_lanes),
		.cfg_scr_en(cfg_scr_en), .cfg_fec_en(cfg_fec_en),
		.cfg_nco_sync_en(cfg_nco_sync_en), .cfg_mf_len(cfg_mf_len),
		.sync_req_n(sync_req_n), .sysref(sysref), .s_valid(s_valid),
		.s_ready(s_ready), .s_data(s_data), .lane_octet(lane_octet),
		.lane_is_k(lane_is_k), .lane_hdr(lane_hdr), .lane_par(lane_par),
		.lane_en(lane_en), .blk_start(blk_start), .fec_active(fec_active),
		.nco_sync(nco_sync), .link_up(link_up), .features(features));
	jtx_rx_model jtx_rx_model_inst (.ref_clk(ref_clk), .go(go), .lag(lag),
		.octet0(lane_octet[7:0]), .is_k0(lane_is_k[0]),
		.sync_req_n(sync_req_n));

	// Fixed-seed xorshift keeps every run repeatable
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Self-synchronous descrambler, 1 + x^14 + x^15, history starts all ones
	function automatic jtx_word_t unscr(input jtx_word_t o);
		jtx_word_t d;
		for (int i = 0; i < 16; i++) begin
			for (int b = 7; b >= 0; b--) begin
				d[8*i+b] = o[8*i+b] ^ hist[i][13] ^ hist[i][14];
				hist[i] = {hist[i][13:0], o[8*i+b]};
			end
		end
		return d;
	endfunction

	// Supported set: 8b10b, 64b66b, FEC, sync pin, sc1, lane align, A/B timing
	function automatic logic [13:0] feat_exp();
		return {2'b11, 4'b0101, 4'b0101, 4'b0011};
	endfunction

	task automatic final_report();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic do_reset(input logic m64, input logic [4:0] n);
		@(negedge ref_clk);
		rst = 1'b1;
		go = 1'b0;
		cfg_mode64 = m64;
		cfg_lanes = n;
		lmask = 16'((17'h1 << n) - 17'h1);
		repeat (5) @(negedge ref_clk);
		`CHK(lane_octet, {16{8'hBC}})
		`CHK(link_up, 1'b0)
		rst = 1'b0;
		@(negedge ref_clk);
		`CHK(lane_en, lmask)
		for (int k = 0; k < 16; k++) begin
			msk[8*k +: 8] = {8{lmask[k]}};
		end
	endtask

	// Offer words only while ready is high; queue what is taken
	task automatic fill(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			@(negedge ref_clk);
			s_valid = s_ready;
			s_data = {xs(), xs(), xs(), xs()};
			if (s_ready === 1'b1) begin
				exp_q.push_back(s_data);
				cnt++;
			end
		end
		@(negedge ref_clk);
		s_valid = 1'b0;
	endtask

	// 8B/10B bring-up: fill while idle, commas, ILAS phase, data drain
	task automatic run8(input logic [3:0] lg, input logic sc, output int ph);
		int ts, ti, ta, n1c, k;
		jtx_word_t dw;
		do_reset(1'b0, 5'(1 + xs() % 16));
		cfg_scr_en = sc;
		for (int i = 0; i < 16; i++) begin
			hist[i] = '1;
		end
		repeat (3 + xs() % 8) @(negedge ref_clk);
		sysref = 1'b1;
		ts = cyc;
		repeat (4) @(negedge ref_clk);
		sysref = 1'b0;
		fill(40, got);
		`CHK(got, 32)
		lag = lg;
		go = 1'b1;
		for (k = 0; k < 20 && sync_req_n !== 1'b0; k++) @(negedge ref_clk);
		repeat (5) @(negedge ref_clk);
		`CHK(lane_octet & msk, {16{8'hBC}} & msk)
		`CHK(lane_is_k & lmask, lmask)
		n1c = 0;
		ti = 0;
		ta = 0;
		for (k = 0; k < 500 && link_up !== 1'b1; k++) begin
			if (lane_is_k[0] === 1'b1 && lane_octet[7:0] === 8'h1C) begin
				if (n1c == 0) ti = cyc;
				n1c++;
			end
			if (lane_is_k[0] === 1'b1 && lane_octet[7:0] === 8'h7C && ta == 0)
				ta = cyc;
			@(negedge ref_clk);
		end
		`CHK(n1c, 4)
		`CHK(ta - ti, int'(cfg_mf_len))
		ph = (ti - ts) % (int'(cfg_mf_len) + 1);
		// First data word follows the last /A/ by exactly one cycle
		@(negedge ref_clk);
		while (exp_q.size() > 0) begin
			w = exp_q.pop_front();
			dw = sc ? unscr(lane_octet) : lane_octet;
			`CHK(dw & msk, w & msk)
			`CHK(lane_is_k & lmask, 16'h0)
			@(negedge ref_clk);
		end
		dw = sc ? unscr(lane_octet) : lane_octet;
		`CHK(dw & msk, 128'h0)
	endtask

	// 64B/66B: no handshake needed, headers, FEC, blocks, NCO sync
	task automatic run64();
		int k, t0;
		do_reset(1'b1, 5'h10);
		cfg_fec_en = 1'b1;
		cfg_nco_sync_en = 1'b1;
		go = 1'b1;
		repeat (20) @(negedge ref_clk);
		`CHK(link_up, 1'b1)
		`CHK(lane_hdr, {16{2'b01}})
		`CHK(fec_active, 1'b1)
		// Parity of one block is the XOR of its eight octets per lane
		for (k = 0; k < 10 && blk_start !== 1'b1; k++) @(negedge ref_clk);
		w = '0;
		repeat (8) begin
			w ^= lane_octet;
			@(negedge ref_clk);
		end
		`CHK(blk_start, 1'b1)
		`CHK(lane_par, w)
		cfg_fec_en = 1'b0;
		#1;
		`CHK(fec_active, 1'b0)
		for (k = 0; k < 10 && blk_start !== 1'b1; k++) @(negedge ref_clk);
		t0 = cyc;
		@(negedge ref_clk);
		for (k = 0; k < 10 && blk_start !== 1'b1; k++) @(negedge ref_clk);
		`CHK(cyc - t0, 8)
		go = 1'b0;
		repeat (6) @(negedge ref_clk);
		go = 1'b1;
		got = 0;
		repeat (10) begin
			@(negedge ref_clk);
			got += int'(nco_sync === 1'b1);
		end
		`CHK(got, 1)
		`CHK(link_up, 1'b1)
		w = {xs(), xs(), xs(), xs()};
		s_data = w;
		s_valid = 1'b1;
		@(negedge ref_clk);
		s_valid = 1'b0;
		got = 0;
		repeat (4) begin
			@(negedge ref_clk);
			got += int'(lane_octet === w);
		end
		`CHK(got, 0)
	endtask

	// Main sequence
	initial begin
		cfg_mf_len = 10'(7 + xs() % 14);
		run8(4'h0, 1'b0, ph0);
		run8(4'hA, 1'b1, ph1);
		`CHK(ph1, ph0)
		`CHK(features, feat_exp())
		run64();
		final_report();
	end

	// Watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		final_report();
	end
endmodule // jtx_link_test
